// File: ihdc_defines.vh
// Purpose: constants for the idle/halt/dual clock control block
// Assumes: one 100 MHz system clock, Avalon-MM register access
// Notes: word addresses of 32-bit registers
`ifndef IHDC_DEFINES_VH
`define IHDC_DEFINES_VH
// register word offsets
`define IHDC_ADDR_PORTG 4'h0
`define IHDC_ADDR_IDLE_TIMER_MODE_REG 4'h1
`define IHDC_ADDR_IRQ_CONTROL_REG 4'h2
`define IHDC_ADDR_STATUS 4'h3
// port g bits
`define IHDC_PG_IDLE 6
`define IHDC_PG_HALT 7
// mode register fields
`define IHDC_IDLE_TIMER_MODE_REG_SLOW_ON 7
`define IHDC_IDLE_TIMER_MODE_REG_FAST_ON 6
`define IHDC_IDLE_TIMER_MODE_REG_TICK_SRC 5
`define IHDC_IDLE_TIMER_MODE_REG_CORE_SEL 4
`define IHDC_IDLE_TIMER_MODE_REG_RESET 8'h40
// control register fields
`define IHDC_IC_PEND 5
`define IHDC_IC_EN 4
// tap base: window select 0 uses timer bit 12 (4096 timer ticks)
`define IHDC_TAP_BASE 5'h0c
`define IHDC_WAKE_LOAD 9'h100
`define IHDC_INSTR_DIV 3'h5
`endif

// File: ihdc_ctrl.v
// Purpose: idle, halt and dual clock mode control with a tick timer that counts only in run and idle
// Assumes: osc clocks arrive as async level inputs, sampled through two flops
// Notes: fast_tick uses a divide-by-five instruction clock; slow edges from a pin
`include "ihdc_defines.vh"

module ihdc_ctrl #(
    parameter TMR_W = 16,
    parameter WAKE_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire ext_reset_n_i,
    input wire slow_clk_i,
    input wire osc_strong_i,
    input wire [WAKE_W-1:0] wake_pins_i,
    input wire halt_disable_i,
    output wire core_run_o,
    output wire core_clk_slow_o,
    output wire fast_osc_on_o,
    output wire slow_osc_on_o,
    output wire tick_irq_o,
    output wire self_reset_o
);

    // ----------------------------------------
    // state codes
    // ----------------------------------------
    localparam ST_RUN = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_HALT = 2'h2;
    localparam ST_WAKE = 2'h3;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] idle_timer_mode_reg_ff;
    reg tick_irq_enable_ff;
    reg tick_pending_flag_ff;
    reg [WAKE_W-1:0] wake_en_ff;
    reg [WAKE_W-1:0] wake_pol_ff;
    reg [TMR_W-1:0] tick_timer_ff;
    reg [8:0] wake_cnt_ff;
    reg [2:0] div_ff;
    reg [2:0] slow_sync_ff;
    reg [1:0] strong_sync_ff;
    reg [1:0] rstn_sync_ff;
    reg [1:0] hdis_sync_ff;
    reg [WAKE_W-1:0] wake_s1_ff;
    reg [WAKE_W-1:0] wake_s2_ff;
    reg [WAKE_W-1:0] wake_s3_ff;
    reg self_rst_ff;
    reg ack_ff;

    wire [2:0] window_select_bits = idle_timer_mode_reg_ff[2:0];
    wire slow_osc_on = idle_timer_mode_reg_ff[`IHDC_IDLE_TIMER_MODE_REG_SLOW_ON];
    wire fast_osc_on = idle_timer_mode_reg_ff[`IHDC_IDLE_TIMER_MODE_REG_FAST_ON];
    wire tick_clock_source = idle_timer_mode_reg_ff[`IHDC_IDLE_TIMER_MODE_REG_TICK_SRC];
    wire core_clock_select = idle_timer_mode_reg_ff[`IHDC_IDLE_TIMER_MODE_REG_CORE_SEL];
    wire req = avs_read_i | avs_write_i;
    wire wr = avs_write_i & ack_ff;
    wire instr_tick = (div_ff == 3'h0);
    wire slow_edge = slow_sync_ff[1] & ~slow_sync_ff[2];
    wire ext_rst_low = ~rstn_sync_ff[1];
    // strap is a pin, so it is read only after two flops
    wire halt_off = hdis_sync_ff[1];

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // second stage alone feeds logic; third stage only for edge detect
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slow_sync_ff <= 3'h0;
            strong_sync_ff <= 2'h0;
            rstn_sync_ff <= 2'h3;
            hdis_sync_ff <= 2'h0;
            wake_s1_ff <= {WAKE_W{1'b0}};
            wake_s2_ff <= {WAKE_W{1'b0}};
            wake_s3_ff <= {WAKE_W{1'b0}};
        end else begin
            slow_sync_ff <= {slow_sync_ff[1:0], slow_clk_i};
            strong_sync_ff <= {strong_sync_ff[0], osc_strong_i};
            rstn_sync_ff <= {rstn_sync_ff[0], ext_reset_n_i};
            hdis_sync_ff <= {hdis_sync_ff[0], halt_disable_i};
            wake_s1_ff <= wake_pins_i;
            wake_s2_ff <= wake_s1_ff;
            wake_s3_ff <= wake_s2_ff;
        end
    end

    // ----------------------------------------
    // wake-up edge detect per pin
    // ----------------------------------------
    wire [WAKE_W-1:0] wake_hit;
    genvar gi;
    generate
        for (gi = 0; gi < WAKE_W; gi = gi + 1) begin : g_wake
            // polarity 1 senses a falling edge, 0 a rising edge
            assign wake_hit[gi] = wake_en_ff[gi] &
                (wake_pol_ff[gi] ? (wake_s3_ff[gi] & ~wake_s2_ff[gi]) : (~wake_s3_ff[gi] & wake_s2_ff[gi]));
        end
    endgenerate

    // ----------------------------------------
    // tick timer clocking
    // ----------------------------------------
    // source select
    wire dual_src = tick_clock_source;
    wire tmr_adv = (state_ff == ST_RUN || state_ff == ST_IDLE) && (dual_src ? slow_edge : instr_tick);
    wire [TMR_W-1:0] tmr_nxt = tick_timer_ff + {{(TMR_W-1){1'b0}}, 1'b1};
    // tap select, window 0 to 4 maps bit 12 to 16
    wire [4:0] tap = `IHDC_TAP_BASE + ((window_select_bits > 3'h4) ? 5'h4 : {2'h0, window_select_bits});
    wire tap_evt = tmr_adv & (tmr_nxt[tap[3:0]] ^ tick_timer_ff[tap[3:0]]) & (tap != 5'h10) |
        tmr_adv & (tap == 5'h10) & (tmr_nxt == {TMR_W{1'b0}});

    // legal combinations of the four control bits
    reg illegal;
    always @* begin
        case (idle_timer_mode_reg_ff[7:4])
            4'h4, 4'hc, 4'he, 4'hf, 4'hb: illegal = 1'b0;
            default: illegal = 1'b1;
        endcase
    end

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (wr && avs_address_i == `IHDC_ADDR_PORTG && avs_writedata_i[`IHDC_PG_HALT] && !halt_off)
                    nxt_state = ST_HALT;
                else if (wr && avs_address_i == `IHDC_ADDR_PORTG && avs_writedata_i[`IHDC_PG_IDLE])
                    nxt_state = ST_IDLE;
            end
            ST_IDLE: begin
                // leave on tap toggle or wake pin
                if (tap_evt || |wake_hit)
                    nxt_state = ST_RUN;
            end
            ST_HALT: begin
                if (|wake_hit)
                    nxt_state = core_clock_select ? ST_RUN : ST_WAKE;
            end
            ST_WAKE: begin
                if (wake_cnt_ff == 9'h0)
                    nxt_state = ST_RUN;
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    // ----------------------------------------
    // registers and counters
    // ----------------------------------------
    // reset clears mode to high speed and ends idle/halt
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= ST_RUN;
            idle_timer_mode_reg_ff <= `IHDC_IDLE_TIMER_MODE_REG_RESET;
            tick_irq_enable_ff <= 1'b0;
            tick_pending_flag_ff <= 1'b0;
            wake_en_ff <= {WAKE_W{1'b0}};
            wake_pol_ff <= {WAKE_W{1'b0}};
            tick_timer_ff <= {TMR_W{1'b0}};
            wake_cnt_ff <= `IHDC_WAKE_LOAD;
            div_ff <= 3'h0;
            self_rst_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else if (ext_rst_low || self_rst_ff) begin
            // synchronous device reset from pin or illegal mode
            state_ff <= ST_RUN;
            idle_timer_mode_reg_ff <= `IHDC_IDLE_TIMER_MODE_REG_RESET;
            tick_irq_enable_ff <= 1'b0;
            tick_pending_flag_ff <= 1'b0;
            wake_en_ff <= {WAKE_W{1'b0}};
            wake_cnt_ff <= `IHDC_WAKE_LOAD;
            self_rst_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ack_ff <= req & ~ack_ff;
            // instruction clock is one fifth of the fast clock
            div_ff <= (div_ff == `IHDC_INSTR_DIV - 3'h1) ? 3'h0 : div_ff + 3'h1;
            if (tmr_adv)
                tick_timer_ff <= tmr_nxt;
            self_rst_ff <= illegal;
            // load on halt, count while oscillation strong
            if (state_ff == ST_HALT)
                wake_cnt_ff <= `IHDC_WAKE_LOAD;
            else if (state_ff == ST_WAKE && instr_tick && strong_sync_ff[1] && wake_cnt_ff != 9'h0)
                wake_cnt_ff <= wake_cnt_ff - 9'h1;
            if (wr && avs_address_i == `IHDC_ADDR_IDLE_TIMER_MODE_REG)
                idle_timer_mode_reg_ff <= avs_writedata_i[7:0];
            if (wr && avs_address_i == `IHDC_ADDR_IRQ_CONTROL_REG) begin
                tick_irq_enable_ff <= avs_writedata_i[`IHDC_IC_EN];
                wake_en_ff <= avs_writedata_i[8 +: WAKE_W];
                wake_pol_ff <= avs_writedata_i[16 +: WAKE_W];
            end
            // set wins over a simultaneous zero write
            if (tap_evt)
                tick_pending_flag_ff <= 1'b1;
            else if (wr && avs_address_i == `IHDC_ADDR_IRQ_CONTROL_REG && !avs_writedata_i[`IHDC_IC_PEND])
                tick_pending_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0;
        end else if (avs_read_i && !ack_ff) begin
            case (avs_address_i)
                `IHDC_ADDR_PORTG: avs_readdata_o <= {24'h0, state_ff == ST_HALT, state_ff == ST_IDLE, 6'h0};
                `IHDC_ADDR_IDLE_TIMER_MODE_REG: avs_readdata_o <= {24'h0, idle_timer_mode_reg_ff};
                `IHDC_ADDR_IRQ_CONTROL_REG: avs_readdata_o <= {{(16-WAKE_W){1'b0}}, wake_pol_ff, {(8-WAKE_W){1'b0}}, wake_en_ff,
                    2'h0, tick_pending_flag_ff, tick_irq_enable_ff, 4'h0};
                `IHDC_ADDR_STATUS: avs_readdata_o <= {28'h0, illegal, tick_clock_source, state_ff};
                default: avs_readdata_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // one wait cycle per access keeps the slave trivially timed
    assign avs_waitrequest_o = req & ~ack_ff;
    // core resumes; irq taken after current instruction by the core
    assign core_run_o = (state_ff == ST_RUN);
    assign core_clk_slow_o = core_clock_select;
    // fast oscillator gated off in halt
    assign fast_osc_on_o = fast_osc_on & (state_ff != ST_HALT);
    assign slow_osc_on_o = slow_osc_on;
    assign tick_irq_o = tick_pending_flag_ff & tick_irq_enable_ff;
    assign self_reset_o = self_rst_ff;

endmodule

// File: ihdc_chk_sva.sv
// Purpose: port-level checks for ihdc_ctrl
// Assumes: one clock domain, rst_i async active high
// Notes: sees only the top ports; bound below
module ihdc_chk_sva (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire avs_waitrequest_o,
    input wire ext_reset_n_i,
    input wire halt_disable_i,
    input wire core_run_o,
    input wire core_clk_slow_o,
    input wire fast_osc_on_o,
    input wire slow_osc_on_o,
    input wire tick_irq_o,
    input wire self_reset_o
);
    // ----
    // sequences
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // only five nibbles form the legal mode ladder
    wire nib_ok = avs_writedata_i[7:4] inside {4'h4, 4'hc, 4'he, 4'hf, 4'hb};
    sequence s_wr(a);
        avs_write_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence
    // pin reset needs two sync flops plus one edge to land
    sequence s_ext_low;
        !ext_reset_n_i [*5];
    endsequence
    // ----
    // properties
    // ----
    property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    property p_idle; (s_wr(4'h0) ##0 avs_writedata_i[7:6] == 2'b01) |=> !core_run_o; endproperty
    property p_halt; (s_wr(4'h0) ##0 avs_writedata_i[7] && !halt_disable_i) |=> ##[0:2] !core_run_o; endproperty
    property p_nohalt;
        (s_wr(4'h0) ##0 avs_writedata_i[7:6] == 2'b10 && halt_disable_i && core_run_o) |=> core_run_o [*3];
    endproperty
    property p_bad; (s_wr(4'h1) ##0 !nib_ok) |=> ##1 self_reset_o; endproperty
    property p_pulse; self_reset_o |=> !self_reset_o; endproperty
    property p_irq_off; (s_wr(4'h2) ##0 !avs_writedata_i[4]) |=> !tick_irq_o; endproperty
    property p_osc;
        (s_wr(4'h1) ##0 nib_ok) |=> slow_osc_on_o == $past(avs_writedata_i[7])
            && fast_osc_on_o == $past(avs_writedata_i[6]) && core_clk_slow_o == $past(avs_writedata_i[4]);
    endproperty
    property p_ext; s_ext_low |-> core_run_o && fast_osc_on_o && !slow_osc_on_o && !core_clk_slow_o; endproperty
    a_ans: assert property (p_ans) else $error("waitrequest held past first cycle");
    a_idle: assert property (p_idle) else $error("idle write did not stop core");
    a_halt: assert property (p_halt) else $error("halt write did not stop core");
    a_nohalt: assert property (p_nohalt) else $error("halt taken while disabled");
    a_bad: assert property (p_bad) else $error("illegal mode without self reset");
    a_pulse: assert property (p_pulse) else $error("self reset longer than one cycle");
    a_irq_off: assert property (p_irq_off) else $error("irq while enable clear");
    a_osc: assert property (p_osc) else $error("clock outputs differ from mode bits");
    a_ext: assert property (p_ext) else $error("pin reset left wrong mode");
endmodule

bind ihdc_ctrl ihdc_chk_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_reset_n_i(ext_reset_n_i), .halt_disable_i(halt_disable_i),
    .core_run_o(core_run_o), .core_clk_slow_o(core_clk_slow_o), .fast_osc_on_o(fast_osc_on_o),
    .slow_osc_on_o(slow_osc_on_o), .tick_irq_o(tick_irq_o), .self_reset_o(self_reset_o));

// File: tb.sv
// Purpose: self-checking bench for ihdc_ctrl
// Assumes: 100 MHz clk_i, Avalon-MM master tasks below
// Notes: random traffic from an 8-bit lfsr seeded at 86
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
    logic ext_reset_n_i = 1, slow_clk_i = 0, osc_strong_i = 1, halt_disable_i = 0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, d;
    logic [7:0] wake_pins_i = 8'h00, lf = 8'h56;
    logic avs_waitrequest_o, core_run_o, core_clk_slow_o, fast_osc_on_o, slow_osc_on_o, tick_irq_o, self_reset_o;
    int err_total = 0, checks = 0, cyc = 0, n;
    ihdc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_reset_n_i(ext_reset_n_i), .slow_clk_i(slow_clk_i),
        .osc_strong_i(osc_strong_i), .wake_pins_i(wake_pins_i), .halt_disable_i(halt_disable_i),
        .core_run_o(core_run_o), .core_clk_slow_o(core_clk_slow_o), .fast_osc_on_o(fast_osc_on_o),
        .slow_osc_on_o(slow_osc_on_o), .tick_irq_o(tick_irq_o), .self_reset_o(self_reset_o));
    always #5 clk_i = ~clk_i;
    // slow osc and hang guard; ceiling covers two idle windows plus wake
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc % 40 == 39) slow_clk_i <= ~slow_clk_i;
        if (cyc == 70000) begin
            err_total++;
            give_verdict;
        end
    end
    function automatic logic [7:0] nxt_lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // window n is 4096 << n instruction ticks of five clocks
    function automatic int win_cyc(input int w);
        return (4096 << w) * 5;
    endfunction
    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dat);
        int t;
        t = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= dat;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
            t++;
        end while (avs_waitrequest_o !== 1'b0 && t < 50);
        if (t == 50) err_total++;
        q = avs_readdata_o;
        avs_write_i <= 0;
        avs_read_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
        bus(0, a, 32'h0);
        chk(nm, exp, q & m);
    endtask
    // waiting is bounded so a stuck core cannot hang the run
    task automatic wait_run(input int lim);
        n = 0;
        while (core_run_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rdchk(4'h1, 32'hff, 32'h40, "mode reset");
        rdchk(4'h3, 32'h3, 32'h0, "state reset");
        bus(1, 4'h5, 32'hffff);
        rdchk(4'h5, 32'hffffffff, 32'h0, "unmapped");
        // random enable and window; pending masked, the timer may set it
        repeat (6) begin
            lf = nxt_lfsr(lf);
            d = {16'h0, lf, 3'h0, lf[0], 4'h0};
            bus(1, 4'h2, d);
            rdchk(4'h2, 32'hff10, d, "irq ctrl");
            bus(1, 4'h1, {24'h0, 8'h40 | (lf % 8'h05)});
            rdchk(4'h1, 32'hff, {24'h0, 8'h40 | (lf % 8'h05)}, "window");
        end
        $display("test registers done");
        bus(1, 4'h2, 32'h0);
        bus(1, 4'h1, 32'h40);
        bus(1, 4'h2, 32'h0);
        bus(1, 4'h0, 32'h40);
        wait_run(win_cyc(0) + 20);
        chk("free idle", 1'b1, in_rng(n, 1, win_cyc(0) + 10));
        repeat (2) @(posedge clk_i);
        rdchk(4'h2, 32'h20, 32'h20, "pending");
        bus(1, 4'h2, 32'h10);
        bus(1, 4'h0, 32'h40);
        wait_run(win_cyc(0) + 20);
        chk("synced idle", 1'b1, in_rng(n, win_cyc(0) - 60, win_cyc(0) + 10));
        chk("irq up", 1'b1, tick_irq_o);
        bus(1, 4'h2, 32'h100);
        chk("irq off", 1'b0, tick_irq_o);
        $display("test idle done");
        halt_disable_i <= 1;
        bus(1, 4'h0, 32'h80);
        rdchk(4'h3, 32'h3, 32'h0, "halt refused");
        halt_disable_i <= 0;
        bus(1, 4'h0, 32'h80);
        rdchk(4'h3, 32'h3, 32'h2, "halted");
        wake_pins_i <= 8'h01;
        wait_run(1400);
        chk("wake delay", 1'b1, in_rng(n, 1275, 1300));
        $display("test halt done");
        bus(1, 4'h1, 32'hc0);
        bus(1, 4'h1, 32'he0);
        chk("dual core fast", 1'b0, core_clk_slow_o);
        rdchk(4'h3, 32'h4, 32'h4, "tick slow");
        bus(1, 4'h0, 32'h80);
        ext_reset_n_i <= 0;
        repeat (5) @(posedge clk_i);
        ext_reset_n_i <= 1;
        repeat (4) @(posedge clk_i);
        chk("pin reset run", 1'b1, core_run_o);
        rdchk(4'h1, 32'hff, 32'h40, "pin reset mode");
        bus(1, 4'h1, 32'hc0);
        bus(1, 4'h1, 32'he0);
        bus(1, 4'h1, 32'hf0);
        chk("core slow", 1'b1, core_clk_slow_o);
        bus(1, 4'h1, 32'hb0);
        bus(1, 4'h1, 32'hf0);
        bus(1, 4'h1, 32'he0);
        chk("low to dual", 1'b0, core_clk_slow_o);
        bus(1, 4'h1, 32'h50);
        repeat (3) @(posedge clk_i);
        rdchk(4'h1, 32'hff, 32'h40, "self reset mode");
        $display("test dual done");
        give_verdict;
    end
endmodule
